// ---- design/ssr_pkg.sv ----
// constants for the switch strap and reset control block
package ssr_pkg;
  localparam int SSR_CLK_MHZ = 100;
  localparam int SSR_SLOW_KHZ = 100;
  localparam int SSR_FAST_KHZ = 400;
  // half period of the config bus clock in core cycles
  localparam logic [9:0] SSR_SLOW_HALF =
    10'((SSR_CLK_MHZ * 1000) / (SSR_SLOW_KHZ * 2));
  localparam logic [9:0] SSR_FAST_HALF =
    10'((SSR_CLK_MHZ * 1000) / (SSR_FAST_KHZ * 2));
  localparam logic [3:0] SSR_MODE_NT = 4'h2;
  localparam logic [3:0] SSR_MODE_NT_EE = 4'h3;
  localparam logic [3:0] SSR_MODE_FO = 4'h4;
  localparam logic [3:0] SSR_MODE_FO_EE = 4'h5;
  localparam int SSR_GPIO_W = 8;
  localparam int SSR_ALT_PORT_B_RST = 0;
  localparam int SSR_ALT_PORT_C_RST = 1;
  localparam int SSR_ALT_LINK_A = 2;
  localparam int SSR_ALT_LINK_B = 3;
  localparam int SSR_ALT_LINK_C = 4;
  localparam int SSR_ALT_FAILOVER = 5;
  localparam logic [7:0] SSR_ALT_CAPABLE = 8'h3F;
  localparam logic [7:0] SSR_ALT_OUT_MASK = 8'h1F;
  localparam logic [3:0] SSR_STRAP_RST = 4'h0;
  localparam logic [2:0] SSR_EE_ADDR_HI = 3'h2;
  localparam logic [1:0] SSR_SLV_ADDR_B6 = 2'h3;
  typedef enum logic [2:0] {
    SSR_ST_RESET = 3'b001,
    SSR_ST_HALT = 3'b010,
    SSR_ST_RUN = 3'b100
  } ssr_state_t;
endpackage

// ---- design/ssr_strap_reset.sv ----
// strap capture, reset sequencing and gpio alternate mapping
//
// Function
// RULE1: eeprom bus address from four address straps
// RULE2: config bus clock driven only during accesses
// RULE3: slave responds only to strapped address
// RULE4: all eight pins usable as gpio
// RULE5: gpio0/1 alternate are port B/C resets
// RULE6: gpio2..4 alternate are link-up outputs
// RULE7: gpio5 alternate is failover request input
// RULE8: downstream shared clock strap is reported
// RULE9: upstream shared clock strap is reported
// RULE10: slow strap picks 100 or 400 kHz
// RULE11: bridge reset honoured only in NT modes
// RULE12: fundamental reset clears all logic; the gpio block, bridge_reset_o and the captured straps and their decoded outputs are not cleared by it here
// RULE13: hold strap keeps device halted after reset
// RULE14: clearing hold bit releases to normal run
// RULE15: decode mode straps 0x2..0x5
// RULE16: board never drives reserved mode codes
// RULE17: names ending n are active low
// RULE18: straps sampled in reset, then held
`timescale 1ns/1ps
module ssr_strap_reset (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic fundamental_reset_n_i,
  input wire logic bridge_far_side_reset_n_i,
  input wire logic reset_hold_i,
  input wire logic [3:0] switch_mode_strap_i,
  input wire logic [3:0] eeprom_addr_strap_i,
  input wire logic [3:0] mgmt_slave_addr_strap_i,
  input wire logic cfg_bus_slow_sel_i,
  input wire logic shared_clk_downstream_i,
  input wire logic shared_clk_upstream_i,
  input wire logic hold_bit_clear_i,
  input wire logic cfg_bus_busy_i,
  input wire logic [7:0] gpio_alt_sel_i,
  input wire logic [7:0] gpio_dir_out_i,
  input wire logic [7:0] gpio_out_val_i,
  input wire logic [7:0] gpio_pin_i,
  input wire logic port_b_reset_req_i,
  input wire logic port_c_reset_req_i,
  input wire logic [2:0] link_up_i,
  output logic core_reset_n_o,
  output logic link_fund_reset_o,
  output logic halted_o,
  output logic bridge_reset_o,
  output logic [6:0] eeprom_bus_addr_o,
  output logic [6:0] mgmt_slave_addr_o,
  output logic cfg_bus_clk_o,
  output logic cfg_bus_clk_oe_n_o,
  output logic shared_clk_downstream_o,
  output logic shared_clk_upstream_o,
  output logic [3:0] mode_o,
  output logic mode_nt_o,
  output logic mode_eeprom_init_o,
  output logic mode_failover_o,
  output logic [7:0] gpio_out_o,
  output logic [7:0] gpio_oe_n_o,
  output logic [7:0] gpio_in_o,
  output logic failover_request_o
);
  import ssr_pkg::*;

  // two-flop synchronisers for every pin input
  logic [25:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {fundamental_reset_n_i, bridge_far_side_reset_n_i,
                   reset_hold_i, switch_mode_strap_i, eeprom_addr_strap_i,
                   mgmt_slave_addr_strap_i, cfg_bus_slow_sel_i,
                   shared_clk_downstream_i, shared_clk_upstream_i,
                   gpio_pin_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic fund_rst, brst_n, hold_pin, slow_s, ccds_s, ccus_s;
  logic [3:0] mode_s, eea_s, sla_s;
  logic [7:0] gpio_s;
  always_comb begin
    fund_rst = !pin_s2_q[25]; // [RULE17]
    brst_n = pin_s2_q[24];
    hold_pin = pin_s2_q[23];
    mode_s = pin_s2_q[22:19];
    eea_s = pin_s2_q[18:15];
    sla_s = pin_s2_q[14:11];
    slow_s = pin_s2_q[10];
    ccds_s = pin_s2_q[9];
    ccus_s = pin_s2_q[8];
    gpio_s = pin_s2_q[7:0];
  end

  function automatic logic is_nt(input logic [3:0] m);
    return m == SSR_MODE_NT || m == SSR_MODE_NT_EE ||
           m == SSR_MODE_FO || m == SSR_MODE_FO_EE; // [RULE15]
  endfunction

  // straps follow the pins while in reset, frozen afterwards
  logic [3:0] mode_q, eea_q, sla_q;
  logic slow_q, ccds_q, ccus_q, hold_strap_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mode_q <= SSR_STRAP_RST;
      eea_q <= SSR_STRAP_RST;
      sla_q <= SSR_STRAP_RST;
      slow_q <= 1'b0;
      ccds_q <= 1'b0;
      ccus_q <= 1'b0;
      hold_strap_q <= 1'b0;
    end else if (fund_rst) begin // [RULE18]
      mode_q <= mode_s;
      eea_q <= eea_s;
      sla_q <= sla_s;
      slow_q <= slow_s;
      ccds_q <= ccds_s;
      ccus_q <= ccus_s;
      hold_strap_q <= hold_pin; // [RULE13]
    end
  end

  // reset sequencer
  ssr_state_t state_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= SSR_ST_RESET;
    end else if (fund_rst) begin
      state_q <= SSR_ST_RESET; // [RULE12]
    end else begin
      case (state_q)
        SSR_ST_RESET: begin
          state_q <= hold_strap_q ? SSR_ST_HALT : SSR_ST_RUN; // [RULE13]
        end
        SSR_ST_HALT: begin
          if (hold_bit_clear_i) begin
            state_q <= SSR_ST_RUN; // [RULE14]
          end
        end
        SSR_ST_RUN: begin
          state_q <= SSR_ST_RUN;
        end
        default: begin
          state_q <= SSR_ST_RESET;
        end
      endcase
    end
  end

  // status and decoded straps
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      core_reset_n_o <= 1'b0;
      link_fund_reset_o <= 1'b1;
      halted_o <= 1'b0;
      bridge_reset_o <= 1'b0;
      eeprom_bus_addr_o <= '0;
      mgmt_slave_addr_o <= '0;
      shared_clk_downstream_o <= 1'b0;
      shared_clk_upstream_o <= 1'b0;
      mode_o <= SSR_STRAP_RST;
      mode_nt_o <= 1'b0;
      mode_eeprom_init_o <= 1'b0;
      mode_failover_o <= 1'b0;
    end else begin
      core_reset_n_o <= (state_q == SSR_ST_RUN) && !fund_rst; // [RULE12]
      link_fund_reset_o <= fund_rst; // [RULE12]
      halted_o <= state_q == SSR_ST_HALT; // [RULE13]
      bridge_reset_o <= !brst_n && is_nt(mode_q); // [RULE11]
      eeprom_bus_addr_o <= {SSR_EE_ADDR_HI, eea_q}; // [RULE1]
      // bits 6, 4 and 0 are fixed; straps land on bits 5 and 3..1
      mgmt_slave_addr_o <= {SSR_SLV_ADDR_B6[1], sla_q[3], 1'b0,
                            sla_q[2:0], 1'b0}; // [RULE3]
      shared_clk_downstream_o <= ccds_q; // [RULE8]
      shared_clk_upstream_o <= ccus_q; // [RULE9]
      mode_o <= mode_q;
      mode_nt_o <= is_nt(mode_q); // [RULE15]
      mode_eeprom_init_o <= mode_q == SSR_MODE_NT_EE ||
                            mode_q == SSR_MODE_FO_EE;
      mode_failover_o <= mode_q == SSR_MODE_FO || mode_q == SSR_MODE_FO_EE;
    end
  end

  // config bus clock: divider runs only while the engine is busy
  // halted state still lets the engine run so registers stay reachable
  logic [9:0] div_q;
  logic [9:0] half;
  assign half = slow_q ? SSR_SLOW_HALF : SSR_FAST_HALF; // [RULE10]
  always_ff @(posedge clk_i) begin
    if (!rstn_i || fund_rst || !cfg_bus_busy_i) begin
      div_q <= '0;
      cfg_bus_clk_o <= 1'b0;
      cfg_bus_clk_oe_n_o <= 1'b1; // [RULE2]
    end else begin
      cfg_bus_clk_oe_n_o <= cfg_bus_clk_o; // open drain: drive low only
      if (div_q == half - 10'h001) begin
        div_q <= '0;
        cfg_bus_clk_o <= !cfg_bus_clk_o; // [RULE2]
      end else begin
        div_q <= div_q + 10'h001;
      end
    end
  end

  // gpio mux
  logic [7:0] alt_val, alt_en;
  always_comb begin
    alt_en = gpio_alt_sel_i & SSR_ALT_CAPABLE; // [RULE4]
    alt_val = '0;
    alt_val[SSR_ALT_PORT_B_RST] = !port_b_reset_req_i; // [RULE5]
    alt_val[SSR_ALT_PORT_C_RST] = !port_c_reset_req_i; // [RULE5]
    alt_val[SSR_ALT_LINK_A] = !link_up_i[0]; // [RULE6]
    alt_val[SSR_ALT_LINK_B] = !link_up_i[1]; // [RULE6]
    alt_val[SSR_ALT_LINK_C] = !link_up_i[2]; // [RULE6]
  end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gpio_out_o <= '0;
      gpio_oe_n_o <= '1;
      gpio_in_o <= '0;
      failover_request_o <= 1'b0;
    end else begin
      for (int i = 0; i < SSR_GPIO_W; i++) begin
        if (alt_en[i]) begin
          gpio_out_o[i] <= alt_val[i];
          gpio_oe_n_o[i] <= !SSR_ALT_OUT_MASK[i]; // [RULE5]
        end else begin
          gpio_out_o[i] <= gpio_out_val_i[i];
          gpio_oe_n_o[i] <= !gpio_dir_out_i[i]; // [RULE4]
        end
      end
      gpio_in_o <= gpio_s;
      failover_request_o <= alt_en[SSR_ALT_FAILOVER] &&
                            gpio_s[SSR_ALT_FAILOVER]; // [RULE7]
    end
  end

  property p_bridge_gate;
    @(posedge clk_i) disable iff (!rstn_i)
    bridge_reset_o |-> $past(is_nt(mode_q)); // [RULE11]
  endproperty
  a_bridge_gate: assert property (p_bridge_gate) // [RULE11]
    else $error("bridge reset outside nt mode");

  property p_fund;
    @(posedge clk_i) disable iff (!rstn_i)
    fund_rst |=> !core_reset_n_o && link_fund_reset_o;
  endproperty
  a_fund: assert property (p_fund) // [RULE12]
    else $error("fundamental reset not applied");

  property p_halt;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == SSR_ST_HALT && !hold_bit_clear_i && !fund_rst)
      |=> state_q == SSR_ST_HALT ##1 halted_o;
  endproperty
  a_halt: assert property (p_halt) // [RULE13]
    else $error("halt left early");

  property p_release;
    @(posedge clk_i) disable iff (!rstn_i)
    (state_q == SSR_ST_HALT && hold_bit_clear_i && !fund_rst)
      |=> state_q == SSR_ST_RUN;
  endproperty
  a_release: assert property (p_release) // [RULE14]
    else $error("halt not released");

  property p_clk_idle;
    @(posedge clk_i) disable iff (!rstn_i)
    !cfg_bus_busy_i |=> cfg_bus_clk_oe_n_o;
  endproperty
  a_clk_idle: assert property (p_clk_idle) // [RULE2]
    else $error("config clock driven while idle");

  property p_strap_hold;
    @(posedge clk_i) disable iff (!rstn_i)
    !fund_rst |=> $stable(mode_q) && $stable(slow_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) // [RULE18]
    else $error("strap changed outside reset");

  property p_failover;
    @(posedge clk_i) disable iff (!rstn_i)
    failover_request_o |-> $past(alt_en[SSR_ALT_FAILOVER]);
  endproperty
  a_failover: assert property (p_failover) // [RULE7]
    else $error("failover without alternate select");

  property p_no_alt67;
    @(posedge clk_i) disable iff (!rstn_i)
    $past(gpio_dir_out_i[7:6]) == ~gpio_oe_n_o[7:6];
  endproperty
  a_no_alt67: assert property (p_no_alt67) // [RULE4]
    else $error("gpio 6/7 took an alternate");

  c_halt: cover property (@(posedge clk_i) state_q == SSR_ST_HALT
                          ##1 state_q == SSR_ST_RUN);
  c_bridge: cover property (@(posedge clk_i) bridge_reset_o);
  c_clk: cover property (@(posedge clk_i) cfg_bus_busy_i
                         ##[1:300] !cfg_bus_clk_oe_n_o);
endmodule

// ---- sim/ssr_board_model.sv ----
// board straps, system reset source and hold clear pulse
`timescale 1ns/1ps
module ssr_board_model (
  input wire logic clk_i,
  output logic fund_n_o,
  output logic bridge_n_o,
  output logic hold_o,
  output logic hold_clr_o,
  output logic slow_o,
  output logic ds_o,
  output logic us_o,
  output logic [3:0] mode_o,
  output logic [3:0] ee_o,
  output logic [3:0] sl_o
);
  initial begin
    {fund_n_o, bridge_n_o, hold_o, hold_clr_o} = 4'h4;
    {slow_o, ds_o, us_o, mode_o, ee_o, sl_o} = 15'h0200;
  end
  // resistors never present a reserved mode code
  task automatic set(input logic [3:0] m, e, s, f);
    @(posedge clk_i);
    #1;
    mode_o = (m < 4'h2 || m > 4'h5) ? 4'h2 : m;
    ee_o = e;
    sl_o = s;
    {hold_o, slow_o, ds_o, us_o} = f;
  endtask
  task automatic fund(input logic v);
    @(posedge clk_i);
    #1;
    fund_n_o = v;
  endtask
  task automatic far(input logic v);
    @(posedge clk_i);
    #1;
    bridge_n_o = v;
  endtask
  task automatic clear_hold();
    @(posedge clk_i);
    #1;
    hold_clr_o = 1'b1;
    @(posedge clk_i);
    #1;
    hold_clr_o = 1'b0;
  endtask
endmodule

// ---- sim/ssr_strap_reset_tb.sv ----
// self-checking bench for the strap and reset control block
`timescale 1ns/1ps
module ssr_strap_reset_tb;
  import ssr_pkg::*;
  typedef struct {string n; int k; logic [31:0] e; logic [31:0] m;} ssr_note_t;
  logic clk_i, rstn_i, busy, pbr, pcr;
  logic fund_n, brg_n, hold, hclr, slow, ds, us;
  logic [3:0] mode, ee, sl, m, e, s, f;
  logic [7:0] alt, dir, oval, pin, ac, eoe;
  logic [2:0] lu;
  logic [31:0] per;
  int err_total, checks_done, cyc, c, i;
  ssr_note_t q[$];
  ssr_note_t nt_;
  event look;
  logic core_n, lfr, hlt, brs, cclk, coe_n, sds, sus, mnt, mei, mfo, fr;
  logic [6:0] eea, sla;
  logic [3:0] md;
  logic [7:0] go, goe, gi;
  ssr_board_model u_brd (.clk_i(clk_i), .fund_n_o(fund_n),
    .bridge_n_o(brg_n), .hold_o(hold), .hold_clr_o(hclr), .slow_o(slow),
    .ds_o(ds), .us_o(us), .mode_o(mode), .ee_o(ee), .sl_o(sl));
  ssr_strap_reset u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
    .fundamental_reset_n_i(fund_n), .bridge_far_side_reset_n_i(brg_n),
    .reset_hold_i(hold), .switch_mode_strap_i(mode),
    .eeprom_addr_strap_i(ee), .mgmt_slave_addr_strap_i(sl),
    .cfg_bus_slow_sel_i(slow), .shared_clk_downstream_i(ds),
    .shared_clk_upstream_i(us), .hold_bit_clear_i(hclr),
    .cfg_bus_busy_i(busy), .gpio_alt_sel_i(alt), .gpio_dir_out_i(dir),
    .gpio_out_val_i(oval), .gpio_pin_i(pin), .port_b_reset_req_i(pbr),
    .port_c_reset_req_i(pcr), .link_up_i(lu), .core_reset_n_o(core_n),
    .link_fund_reset_o(lfr), .halted_o(hlt), .bridge_reset_o(brs),
    .eeprom_bus_addr_o(eea), .mgmt_slave_addr_o(sla), .cfg_bus_clk_o(cclk),
    .cfg_bus_clk_oe_n_o(coe_n), .shared_clk_downstream_o(sds),
    .shared_clk_upstream_o(sus), .mode_o(md), .mode_nt_o(mnt),
    .mode_eeprom_init_o(mei), .mode_failover_o(mfo), .gpio_out_o(go),
    .gpio_oe_n_o(goe), .gpio_in_o(gi), .failover_request_o(fr));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [31:0] act(input int k);
    case (k)
      0: return {28'h0, md};
      1: return {29'h0, mnt, mei, mfo};
      2: return {25'h0, eea};
      3: return {25'h0, sla};
      4: return {30'h0, sds, sus};
      5: return {24'h0, go};
      6: return {24'h0, goe};
      7: return {24'h0, gi};
      8: return {31'h0, fr};
      9: return {29'h0, core_n, hlt, lfr};
      10: return {31'h0, brs};
      11: return {31'h0, coe_n};
      default: return per;
    endcase
  endfunction
  task automatic note(string n, int k, logic [31:0] x, logic [31:0] mk = '1);
    q.push_back('{n, k, x, mk});
    ->look;
  endtask
  task automatic cmp(string n, logic [31:0] x, logic [31:0] g);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", n, x, g);
    end
  endtask
  always @(look) begin
    while (q.size() > 0) begin
      nt_ = q.pop_front();
      cmp(nt_.n, nt_.e & nt_.m, act(nt_.k) & nt_.m);
    end
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      conclude();
    end
  end
  task automatic cyc_wait(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  initial begin
    {rstn_i, busy, pbr, pcr, lu} = 7'h0;
    {alt, dir, oval, pin} = 32'h0;
    per = $urandom(84966);
    cyc_wait(20);
    rstn_i = 1'b1;
    for (i = 0; i < 8; i++) begin
      m = 4'h2 + 4'(i % 4);
      e = 4'($urandom);
      s = 4'($urandom);
      f = {i[0], i[1], 2'($urandom)};
      u_brd.fund(1'b0);
      u_brd.set(m, e, s, f);
      cyc_wait(6);
      note("rst", 9, 32'h1);
      u_brd.fund(1'b1);
      u_brd.set(m ^ 4'h1, ~e, ~s, f ^ 4'h7);
      cyc_wait(8);
      note("mode", 0, {28'h0, m});
      note("flags", 1,
        {29'h0, 1'b1, (m == 4'h3 || m == 4'h5), m[2]});
      note("ee", 2, {25'h0, SSR_EE_ADDR_HI, e});
      note("slv", 3, {25'h0, 1'b1, s[3], 1'b0, s[2:0], 1'b0});
      note("shclk", 4, {30'h0, f[1:0]});
      note("run", 9, {29'h0, ~f[3], f[3], 1'b0});
      if (f[3]) begin
        u_brd.clear_hold();
        cyc_wait(4);
        note("rel", 9, 32'h4);
      end
      u_brd.far(1'b0);
      cyc_wait(5);
      note("brg", 10, 32'h1);
      u_brd.far(1'b1);
      cyc_wait(5);
      note("brg", 10, 32'h0);
      if (i < 4 && !i[0]) begin
        busy = 1'b1;
        fr_count();
        note("half", 12, f[2] ? SSR_SLOW_HALF : SSR_FAST_HALF);
        // pin is pulled low one edge after the clock goes low
        cyc_wait(1);
        note("clkdrv", 11, {31'h0, cclk});
        busy = 1'b0;
        cyc_wait(3);
        note("clkoe", 11, 32'h1);
      end
    end
    for (i = 0; i < 24; i++) begin
      {alt, dir, oval, pin} = $urandom;
      {pbr, pcr, lu} = 5'($urandom);
      cyc_wait(4);
      ac = alt & SSR_ALT_CAPABLE;
      eoe = (ac & 8'h20) | (~ac & ~dir);
      note("oe", 6, {24'h0, eoe});
      note("out", 5, (ac & {3'h0, ~lu, ~pcr, ~pbr}) | (~ac & oval),
        {24'h0, ~eoe});
      note("in", 7, {24'h0, pin});
      if (ac[5]) note("fail", 8, {31'h0, pin[5]});
    end
    cyc_wait(2);
    conclude();
  end
  // counts core cycles between two toggles of the config clock
  task automatic fr_count();
    logic v;
    c = 0;
    v = cclk;
    while (cclk === v && c < 1200) begin
      cyc_wait(1);
      c++;
    end
    v = cclk;
    per = 0;
    while (cclk === v && per < 1200) begin
      cyc_wait(1);
      per++;
    end
  endtask
endmodule
